// file: bench/gpio_port_sva.sv
// concurrent checks on the port block's apb side and pin drivers
// assumes control-register writes always carry lane 0 strobe set
`timescale 1ns/1ps
module gpio_port_chk
   import gpio_port_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [5:0] pin_out,
   input wire logic [5:0] pin_oe,
   input wire logic [5:0] periph_out,
   input wire logic [5:0] periph_oe
);
   // ****************************************
   // mirrors of the control registers
   // ****************************************
   logic [5:0] dir_q, ana_q, per_q; // copies taken at the access edge
   logic [2:0] cfg_q; // reset pin and oscillator mode
   logic [5:0] oe_exp; // driver enables the mirrors predict
   logic wr_a, rd_a, xtal_s; // access qualifiers and crystal-mode flag
   assign wr_a = psel && penable && pwrite;
   assign rd_a = psel && penable && !pwrite;
   assign xtal_s = cfg_q[2:1] != 2'h0;
   // mirror update; same edge as the design so no lag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dir_q <= direction_rst;
         ana_q <= analog_rst;
         per_q <= periph_rst;
         cfg_q <= config_rst;
      end else if (wr_a) begin
         if (paddr == direction_reg_off) dir_q <= pwdata[5:0];
         if (paddr == analog_select_reg_off) ana_q <= pwdata[5:0];
         if (paddr == periph_enable_reg_off) per_q <= pwdata[5:0];
         if (paddr == config_reg_off) cfg_q <= pwdata[2:0];
      end
   end
   // predicted enables: peripheral first, pin three never, crystal pins lost
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         oe_exp[i] = per_q[i] ? periph_oe[i] : !dir_q[i];
      end
      oe_exp[3] = 1'b0;
      if (xtal_s) begin
         oe_exp[5:4] = 2'b00;
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   oe_map_a: assert property (pin_oe == oe_exp)
      else $error("pin enables differ from direction setting");
   input_only_a: assert property (!pin_oe[3] && !pin_out[3])
      else $error("input only pin is driven");
   reset_off_a: assert property ($rose(presetn) |-> pin_oe == 6'h00)
      else $error("pins driven right after reset");
   periph_out_a: assert property (((pin_out ^ periph_out) & per_q & 6'h37) == 6'h00)
      else $error("peripheral value not on its pin");
   upper_zero_a: assert property (rd_a |-> prdata[31:6] == 26'h0)
      else $error("unused read bits not zero");
   dir_read_a: assert property (rd_a && paddr == direction_reg_off
      |-> prdata[3] && (!xtal_s || prdata[5:4] == 2'h3))
      else $error("direction readback wrong");
   analog_zero_a: assert property (rd_a && paddr == pin_value_reg_off
      |-> (prdata[5:0] & ana_q) == 6'h00 && !(cfg_q[0] && prdata[3]))
      else $error("masked pin reads nonzero");
   err_phase_a: assert property (pslverr |-> psel && penable && pready)
      else $error("error outside access phase");
   // refused access answers with an error and, on a read, zero data
   unmapped_a: assert property (psel && penable && paddr > config_reg_off
      |-> pslverr && (pwrite || prdata == 32'h0))
      else $error("unmapped access not refused");
endmodule : gpio_port_chk
bind gpio_port gpio_port_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .pin_out(pin_out), .pin_oe(pin_oe),
   .periph_out(periph_out), .periph_oe(periph_oe));

// file: bench/pin_world.sv
// outside circuitry hanging on the six port pins
// assumes pin_oe high means the block drives the pin
`timescale 1ns/1ps
module pin_world (
   input wire logic [5:0] pin_out,
   input wire logic [5:0] pin_oe,
   input wire logic [5:0] ext_val,
   output logic [5:0] pin_level
);
   // wire level: block driver wins, the outside source is weak
   assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_val);
endmodule : pin_world

// file: bench/tb.sv
// self-checking bench for the six-bit port over apb
// assumes pin levels settle into reads within six edges
`timescale 1ns/1ps
module tb;
   import gpio_port_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0] pstrb = 4'hf;
   logic pready, pslverr, er;
   logic [5:0] pin_in, pin_out, pin_oe, periph_in, ext_val = 6'h2a;
   logic [5:0] periph_out = 6'h00, periph_oe = 6'h00;
   int mismatches = 0, check_count = 0;
   // clock, 50 ns period
   always #25 pclk = ~pclk;
   gpio_port dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
      .pin_oe(pin_oe), .periph_out(periph_out), .periph_oe(periph_oe),
      .periph_in(periph_in));
   pin_world world_u (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val),
      .pin_level(pin_in));
   // ****************************************
   // helpers
   // ****************************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // one apb transfer; held until pready is seen high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      // bound used up with no answer: count it and close the run
      if (pready !== 1'b1) begin
         mismatches++;
         report_and_stop();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // let edges pass, then look just after the last
   task automatic settle(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask : settle
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : report_and_stop
   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_reset();
      apb(1'b0, direction_reg_off, 32'h0);
      chk(rd, 32'h3f);
      apb(1'b0, pin_value_reg_off, 32'h0);
      chk(rd, 32'h0);
      chk(pin_oe, 6'h00);
      $display("test reset done");
   endtask : t_reset
   task automatic t_drive();
      apb(1'b1, analog_select_reg_off, 32'h0); // digital before use
      apb(1'b1, pin_value_reg_off, 32'h15); // latch set while all inputs
      settle(6);
      apb(1'b0, pin_value_reg_off, 32'h0);
      chk(rd, 32'h2a);
      apb(1'b1, direction_reg_off, 32'h0);
      settle(1);
      chk(pin_oe, 6'h37);
      chk(pin_out, 6'h15);
      apb(1'b0, direction_reg_off, 32'h0);
      chk(rd, 32'h08);
      settle(6);
      apb(1'b0, pin_value_reg_off, 32'h0);
      chk(rd, 32'h1d);
      $display("test drive done");
   endtask : t_drive
   task automatic t_cfg();
      apb(1'b1, config_reg_off, 32'h1);
      apb(1'b0, pin_value_reg_off, 32'h0);
      chk(rd, 32'h15);
      for (int m = 1; m < 4; m++) begin
         apb(1'b1, config_reg_off, 32'(m * 2));
         apb(1'b0, direction_reg_off, 32'h0);
         chk(rd, 32'h38);
         chk(pin_oe, 6'h07);
      end
      apb(1'b0, config_reg_off, 32'h0);
      chk(rd, 32'h6);
      apb(1'b1, config_reg_off, 32'h0);
      $display("test config done");
   endtask : t_cfg
   task automatic t_analog();
      apb(1'b1, analog_select_reg_off, 32'h1);
      settle(1);
      chk(pin_oe, 6'h37);
      apb(1'b0, analog_select_reg_off, 32'h0);
      chk(rd, 32'h01);
      apb(1'b0, pin_value_reg_off, 32'h0);
      chk(rd, 32'h1c);
      // lane 0 off: latch takes the masked port view, so analog pin 0 clears
      pstrb <= 4'he;
      apb(1'b1, pin_value_reg_off, 32'h3f);
      pstrb <= 4'hf;
      // latch lands at the access edge; look one edge later
      settle(1);
      chk(pin_out, 6'h14);
      apb(1'b1, analog_select_reg_off, 32'h0);
      $display("test analog done");
   endtask : t_analog
   task automatic t_periph();
      periph_out <= 6'h2a;
      periph_oe <= 6'h3f;
      apb(1'b1, periph_enable_reg_off, 32'h3f);
      settle(6);
      chk(pin_oe, 6'h37);
      chk(pin_out, 6'h22);
      chk(periph_in, 6'h2a);
      apb(1'b0, periph_enable_reg_off, 32'h0);
      chk(rd, 32'h3f);
      apb(1'b1, periph_enable_reg_off, 32'h0);
      apb(1'b1, 12'h020, 32'h0);
      chk(er, 1'b1);
      apb(1'b0, 12'h020, 32'h0);
      chk(er, 1'b1);
      chk(rd, 32'h0);
      $display("test takeover and unmapped done");
   endtask : t_periph
   // main sequence: reset four cycles, then every scenario
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_drive();
      t_cfg();
      t_analog();
      t_periph();
      report_and_stop();
   end
endmodule : tb

// file: src/gpio_port.sv
// six-bit general purpose port with apb register access
// assumes apb master on pclk; pins resolved by the testbench from pin_oe
`timescale 1ns/1ps
module gpio_port
   import gpio_port_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [5:0] pin_in,
   output logic [5:0] pin_out,
   output logic [5:0] pin_oe,
   input wire logic [5:0] periph_out,
   input wire logic [5:0] periph_oe,
   output logic [5:0] periph_in
);
   // ********************************************************************
   // state
   // ********************************************************************
   logic [5:0] latch_q, latch_d; // output data latch
   logic [5:0] dir_q, dir_d; // stored direction bits
   logic [5:0] ana_q, ana_d; // analog marks
   logic [5:0] per_q, per_d; // peripheral enables
   logic [2:0] cfg_q, cfg_d; // reset pin enable and osc mode
   logic [31:0] rdata_q, rdata_d; // read data register
   logic err_q, err_d; // error answer
   logic [5:0] pin_lvl; // filtered pin levels
   logic [5:0] pin_view; // port read value
   logic [5:0] dir_view; // direction read value
   logic xtal_mode; // a crystal mode owns pins five and four
   logic reset_pin_enable; // pin three serves as reset
   osc_mode_t osc_mode;
   logic setup_ph; // setup cycle of a transfer
   logic wr_ph;
   logic rd_ph;

   // ********************************************************************
   // pins
   // ********************************************************************
   pin_sync #(
      .width(port_width)
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .raw_in(pin_in),
      .level_out(pin_lvl)
   );

   pin_drive u_drive (
      .latch(latch_q),
      .dir(dir_q),
      .periph_en(per_q),
      .periph_out(periph_out),
      .periph_oe(periph_oe),
      .xtal_mode(xtal_mode),
      .pin_out(pin_out),
      .pin_oe(pin_oe)
   );

   // peripherals see the live filtered level
   assign periph_in = pin_lvl;

   // ********************************************************************
   // configuration decode
   // ********************************************************************
   // config bits applied straight to reads and drivers, no extra latency
   assign osc_mode = osc_mode_t'(cfg_q[cfg_osc_lo +: 2]);
   assign reset_pin_enable = cfg_q[cfg_reset_pin_bit];
   assign xtal_mode = (osc_mode == crystal_osc_mode) ||
                      (osc_mode == high_speed_crystal_mode) ||
                      (osc_mode == low_power_crystal_mode);

   // byte-lane merge used for every register write except config
   function automatic logic [5:0] lane0(input logic [5:0] old, input logic [31:0] wd,
                                        input logic [3:0] strb);
      lane0 = strb[0] ? wd[5:0] : old;
   endfunction : lane0

   // ********************************************************************
   // read views
   // ********************************************************************
   // analog pins and the reset pin mask the live level
   always_comb begin
      pin_view = pin_lvl & ~ana_q;
      if (reset_pin_enable) begin
         pin_view[input_only_bit] = 1'b0;
      end
      dir_view = dir_q;
      dir_view[input_only_bit] = 1'b1;
      if (xtal_mode) begin
         dir_view[osc_hi_bit] = 1'b1;
         dir_view[osc_lo_bit] = 1'b1;
      end
   end

   // ********************************************************************
   // apb decode
   // ********************************************************************
   // zero wait states: access phase always completes on its first cycle
   assign setup_ph = psel && !penable;
   assign wr_ph = psel && penable && pwrite;
   assign rd_ph = setup_ph && !pwrite;
   assign pready = 1'b1;

   // ********************************************************************
   // register next-state
   // ********************************************************************
   always_comb begin
      latch_d = latch_q;
      dir_d = dir_q;
      ana_d = ana_q;
      per_d = per_q;
      cfg_d = cfg_q;
      err_d = err_q;
      rdata_d = rdata_q;
      // error flag is formed in setup so it is valid with pready
      if (setup_ph) begin
         unique case (paddr)
            pin_value_reg_off, direction_reg_off, analog_select_reg_off,
            periph_enable_reg_off, config_reg_off: begin
               err_d = 1'b0;
            end
            default: begin
               err_d = 1'b1; // unmapped address
            end
         endcase
      end
      // read data is captured in setup and held through access
      if (rd_ph) begin
         rdata_d = '0;
         unique case (paddr)
            pin_value_reg_off: begin
               rdata_d[5:0] = pin_view;
            end
            direction_reg_off: begin
               rdata_d[5:0] = dir_view;
            end
            analog_select_reg_off: begin
               rdata_d[5:0] = ana_q;
            end
            periph_enable_reg_off: begin
               rdata_d[5:0] = per_q;
            end
            config_reg_off: begin
               rdata_d[2:0] = cfg_q;
            end
            default: begin
               rdata_d = '0;
            end
         endcase
      end
      if (wr_ph) begin
         unique case (paddr)
            pin_value_reg_off: begin
               // the port is read first, so pins driven elsewhere can
               // overwrite latch bits nobody meant to touch
               latch_d = lane0(pin_view, pwdata, pstrb);
            end
            direction_reg_off: begin
               // analog pins keep whatever direction software writes
               dir_d = lane0(dir_q, pwdata, pstrb);
            end
            analog_select_reg_off: begin
               ana_d = lane0(ana_q, pwdata, pstrb);
            end
            periph_enable_reg_off: begin
               per_d = lane0(per_q, pwdata, pstrb);
            end
            config_reg_off: begin
               cfg_d = pstrb[0] ? pwdata[2:0] : cfg_q;
            end
            default: begin
               latch_d = latch_q;
            end
         endcase
      end
   end

   // ********************************************************************
   // registers
   // ********************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         latch_q <= latch_rst;
         dir_q <= direction_rst;
         ana_q <= analog_rst;
         per_q <= periph_rst;
         cfg_q <= config_rst;
         rdata_q <= '0;
         err_q <= 1'b0;
      end else begin
         latch_q <= latch_d;
         dir_q <= dir_d;
         ana_q <= ana_d;
         per_q <= per_d;
         cfg_q <= cfg_d;
         rdata_q <= rdata_d;
         err_q <= err_d;
      end
   end

   assign prdata = rdata_q;
   assign pslverr = err_q && psel && penable;
endmodule : gpio_port

// file: src/gpio_port_pkg.sv
// shared constants for the six-bit bidirectional port
// assumes an apb slave with 32-bit data, one aligned word per register
package gpio_port_pkg;
   // ********************************************************************
   // register map
   // ********************************************************************
   localparam logic [11:0] pin_value_reg_off = 12'h000; // pin levels / latch
   localparam logic [11:0] direction_reg_off = 12'h004; // direction bits
   localparam logic [11:0] analog_select_reg_off = 12'h008; // analog marks
   localparam logic [11:0] periph_enable_reg_off = 12'h00c; // peripheral takeover
   localparam logic [11:0] config_reg_off = 12'h010; // reset pin / osc mode
   // ********************************************************************
   // fields and reset values
   // ********************************************************************
   localparam int port_width = 6; // implemented pins
   localparam int input_only_bit = 3; // pin with no driver
   localparam int osc_lo_bit = 4; // first pin lost to crystal
   localparam int osc_hi_bit = 5; // second pin lost to crystal
   localparam int cfg_reset_pin_bit = 0; // reset pin enable
   localparam int cfg_osc_lo = 1; // oscillator mode field low bit
   localparam logic [5:0] direction_rst = 6'h3f; // all inputs after reset
   localparam logic [5:0] latch_rst = 6'h00; // latch value is undefined; zero chosen
   localparam logic [5:0] analog_rst = 6'h3f; // pins start analog
   localparam logic [5:0] periph_rst = 6'h00; // no peripheral owns a pin
   localparam logic [2:0] config_rst = 3'h0; // reset pin off, rc mode
   // oscillator mode codes
   typedef enum logic [1:0] {
      osc_other_mode = 2'h0,
      crystal_osc_mode = 2'h1,
      high_speed_crystal_mode = 2'h2,
      low_power_crystal_mode = 2'h3
   } osc_mode_t;
endpackage : gpio_port_pkg

// file: src/pin_drive.sv
// driver control for the port pins, including peripheral takeover
// assumes peripheral data and enables come from same-clock logic
`timescale 1ns/1ps
module pin_drive
   import gpio_port_pkg::*;
(
   input wire logic [5:0] latch,
   input wire logic [5:0] dir,
   input wire logic [5:0] periph_en,
   input wire logic [5:0] periph_out,
   input wire logic [5:0] periph_oe,
   input wire logic xtal_mode,
   output logic [5:0] pin_out,
   output logic [5:0] pin_oe
);
   // ********************************************************************
   // per-pin driver
   // ********************************************************************
   always_comb begin
      for (int i = 0; i < port_width; i++) begin
         if (periph_en[i]) begin
            pin_out[i] = periph_out[i];
            pin_oe[i] = periph_oe[i];
         end else begin
            pin_out[i] = latch[i];
            pin_oe[i] = !dir[i];
         end
      end
      pin_oe[input_only_bit] = 1'b0;
      pin_out[input_only_bit] = 1'b0;
      // crystal owns the two oscillator pins
      if (xtal_mode) begin
         pin_oe[osc_lo_bit] = 1'b0;
         pin_oe[osc_hi_bit] = 1'b0;
      end
   end
endmodule : pin_drive

// file: src/pin_sync.sv
// three-stage synchroniser with agreement filter for the port pins
// assumes pins are asynchronous to pclk
`timescale 1ns/1ps
module pin_sync #(
   parameter int width = 6
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [width-1:0] raw_in,
   output logic [width-1:0] level_out
);
   // ********************************************************************
   // stages
   // ********************************************************************
   logic [width-1:0] s1_q, s2_q, s3_q; // s1 is only read by s2
   logic [width-1:0] lvl_q, lvl_d; // filtered level
   // accept a change only once stages two and three agree
   always_comb begin
      lvl_d = lvl_q;
      for (int i = 0; i < width; i++) begin
         if (s2_q[i] == s3_q[i]) begin
            lvl_d[i] = s3_q[i];
         end
      end
   end
   // registers only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         lvl_q <= '0;
      end else begin
         s1_q <= raw_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         lvl_q <= lvl_d;
      end
   end
   assign level_out = lvl_q;
endmodule : pin_sync
